//--- src/cdf_direction_finding_ctrl.sv
// Tone extension controller: tone generation, switching and sampling.
// Assumes radio events are one-cycle pulses and header bytes arrive
// one per strobe from the address event onward.
`timescale 1ns/100ps

module cdf_direction_finding_ctrl (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Mode
	input wire logic [1:0] phy_mode,
	input wire logic direction_mode_select,
	input wire logic tx_mode,
	// Inline configuration
	input wire logic inline_cfg_enable,
	input wire logic info_position_select,
	input wire logic [7:0] header_match_mask,
	input wire logic [7:0] header_match_value,
	input wire logic [1:0] duration_valid_range,
	input wire logic [1:0] rx_spacing_short_slots,
	input wire logic [1:0] rx_spacing_long_slots,
	// Manual configuration
	input wire logic [1:0] first_sample_spacing,
	input wire logic [1:0] second_sample_spacing,
	input wire logic [5:0] manual_length_setting,
	input wire logic switch_spacing_long,
	input wire logic procedure_trigger_select,
	input wire logic [7:0] switch_offset,
	input wire logic [7:0] sample_offset,
	// Radio events and header stream
	input wire logic address_event,
	input wire logic crc_end_event,
	input wire logic header_byte_valid,
	input wire logic [7:0] header_byte,
	// Procedure outputs
	output logic cte_tone_tx,
	output logic antenna_switch,
	output logic iq_sample,
	output logic procedure_active,
	output logic cte_info_found,
	output logic [5:0] cte_length_units,
	output logic [1:0] slot_type
);
	// ==========================================================
	// Decoding helpers
	function automatic logic [5:0] spacing_cycles(input logic [1:0] code);
		spacing_cycles = 6'(cdf_pkg::US_CYCLES >> code);
	endfunction

	function automatic logic [5:0] dur_decode(input logic [7:0] info,
			input logic [1:0] range);
		logic [5:0] raw;
		logic [5:0] max;
		raw = range[1] ? info[5:0] : {1'b0, info[4:0]};
		case (range)
			cdf_pkg::RANGE_STD: max = cdf_pkg::CTE_MAX_UNITS;
			cdf_pkg::RANGE_5BIT: max = cdf_pkg::CTE_RANGE_5BIT;
			default: max = cdf_pkg::CTE_RANGE_6BIT;
		endcase
		if (raw < cdf_pkg::CTE_MIN_UNITS) begin
			dur_decode = cdf_pkg::CTE_MIN_UNITS;
		end else if (raw > max) begin
			dur_decode = max;
		end else begin
			dur_decode = raw;
		end
	endfunction

	// ==========================================================
	// State
	cdf_pkg::cdf_state_e state_reg, state_next;
	logic [3:0] idx_reg, idx_next, pos_reg, pos_next;
	logic match_reg, match_next, expect_reg, expect_next;
	logic found_reg, found_next, started_reg, started_next;
	logic [7:0] info_reg, info_next;
	logic [8:0] cte_us_reg, cte_us_next;
	logic [5:0] len_reg, len_next;
	logic [7:0] sw_wait_reg, sw_wait_next, smp_wait_reg, smp_wait_next;
	logic [1:0] sw_gap_reg, sw_gap_next;
	logic [5:0] smp_cyc_reg, smp_cyc_next;
	logic tone_reg, tone_next, sw_reg, sw_next, smp_reg, smp_next;
	logic df_ok, use_inline, gen_cte, smp_cte, sw_cte, run_ok, trig;
	logic us_tick, hdr_match, slot2, guard, in_ref, slot_odd, cte_tick;
	logic sw_phase, smp_phase, sw_blocked;
	logic [1:0] type_now, slot_spacing;
	logic [8:0] rel_us;

	cdf_us_tick u_tick (
		.core_clk(core_clk),
		.reset(reset),
		.restart(trig),
		.us_tick(us_tick)
	);
	// Extension timeline runs from the end of the CRC whatever the trigger
	cdf_us_tick u_cte_tick (
		.core_clk(core_clk),
		.reset(reset),
		.restart(crc_end_event && state_reg == cdf_pkg::ST_HEADER),
		.us_tick(cte_tick)
	);

	// ==========================================================
	// Mode decode
	always_comb begin
		df_ok = phy_mode == cdf_pkg::PHY_1M ||
			phy_mode == cdf_pkg::PHY_2M;
		gen_cte = tx_mode;
		smp_cte = !tx_mode;
		sw_cte = direction_mode_select ? tx_mode : !tx_mode;
		use_inline = inline_cfg_enable && !tx_mode;
		hdr_match = (header_byte & header_match_mask) ==
			header_match_value;
		type_now = info_reg[7:6];
		sw_blocked = use_inline && found_reg &&
			type_now == cdf_pkg::SLOT_RESERVED;
		run_ok = !use_inline || found_reg;
		trig = procedure_trigger_select ? address_event :
			(crc_end_event && state_reg == cdf_pkg::ST_HEADER);
		slot2 = switch_spacing_long;
		slot_spacing = second_sample_spacing;
		if (use_inline && found_reg) begin
			case (type_now)
				cdf_pkg::SLOT_AOD_1US: begin
					slot2 = 1'b0;
					slot_spacing = rx_spacing_short_slots;
				end
				cdf_pkg::SLOT_AOD_2US: begin
					slot2 = 1'b1;
					slot_spacing = rx_spacing_long_slots;
				end
				default: slot_spacing = second_sample_spacing;
			endcase
		end else if (use_inline) begin
			slot_spacing = switch_spacing_long ? rx_spacing_long_slots :
				rx_spacing_short_slots;
		end
		// Phase within the extension; slots are one length for both kinds
		rel_us = cte_us_reg - 9'(cdf_pkg::GUARD_US + cdf_pkg::REF_US);
		guard = cte_us_reg < 9'(cdf_pkg::GUARD_US);
		in_ref = !guard &&
			cte_us_reg < 9'(cdf_pkg::GUARD_US + cdf_pkg::REF_US);
		slot_odd = slot2 ? rel_us[1] : rel_us[0];
		sw_phase = state_reg == cdf_pkg::ST_CTE &&
			(guard || (!in_ref && !slot_odd));
		smp_phase = state_reg == cdf_pkg::ST_CTE &&
			(in_ref || (!guard && slot_odd));
	end

	// ==========================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		pos_next = pos_reg;
		match_next = match_reg;
		expect_next = expect_reg;
		found_next = found_reg;
		info_next = info_reg;
		cte_us_next = cte_us_reg;
		len_next = len_reg;
		started_next = started_reg;
		sw_wait_next = sw_wait_reg;
		sw_gap_next = sw_gap_reg;
		smp_wait_next = smp_wait_reg;
		smp_cyc_next = smp_cyc_reg;
		sw_next = 1'b0;
		smp_next = 1'b0;
		case (state_reg)
			cdf_pkg::ST_IDLE: begin
				if (address_event && df_ok) begin
					state_next = cdf_pkg::ST_HEADER;
					idx_next = 4'h0;
					expect_next = 1'b0;
					found_next = 1'b0;
				end
			end
			cdf_pkg::ST_HEADER: begin
				if (header_byte_valid && use_inline) begin
					idx_next = idx_reg + 4'(idx_reg != 4'hF);
					if (idx_reg == 4'h0) begin
						match_next = hdr_match;
						pos_next = info_position_select ? cdf_pkg::DATA_INFO_IDX :
							cdf_pkg::ADV_INFO_IDX;
						if (info_position_select) begin
							expect_next = hdr_match &&
								header_byte[cdf_pkg::DATA_CP_BIT];
						end
					end
					if (!info_position_select &&
							idx_reg == cdf_pkg::ADV_EXTLEN_IDX) begin
						expect_next = match_reg &&
							header_byte[5:0] != 6'h00;
					end
					if (!info_position_select &&
							idx_reg == cdf_pkg::ADV_FLAGS_IDX) begin
						expect_next = expect_reg &&
							header_byte[cdf_pkg::ADV_INFO_FLAG_BIT];
						if (|header_byte[cdf_pkg::ADV_INFO_FLAG_BIT-1:0]) begin
							pos_next = cdf_pkg::ADV_INFO_IDX +
								cdf_pkg::ADV_INFO_SHIFT;
						end
					end
					if (expect_reg && !found_reg && idx_reg == pos_reg &&
							idx_reg > cdf_pkg::ADV_FLAGS_IDX - 4'h2) begin
						found_next = 1'b1;
						info_next = header_byte;
					end
				end
				if (crc_end_event) begin
					cte_us_next = 9'h000;
					len_next = use_inline ?
						dur_decode(info_reg, duration_valid_range) :
						manual_length_setting;
					state_next = (run_ok && df_ok) ? cdf_pkg::ST_CTE :
						cdf_pkg::ST_IDLE;
				end
			end
			cdf_pkg::ST_CTE: begin
				if (cte_tick) begin
					cte_us_next = cte_us_reg + 9'h001;
					if (cte_us_next == {len_reg, 3'b000}) begin
						state_next = cdf_pkg::ST_IDLE;
					end
				end
			end
			default: state_next = cdf_pkg::ST_IDLE;
		endcase
		// Offsets and slot timers run from the trigger
		if (trig) begin
			started_next = 1'b1;
			sw_wait_next = switch_offset;
			sw_gap_next = 2'h0;
			smp_wait_next = sample_offset;
			smp_cyc_next = 6'h00;
		end else if (started_reg) begin
			if (us_tick) begin
				if (sw_wait_reg != 8'h00) begin
					sw_wait_next = sw_wait_reg - 8'h01;
				end else if (sw_gap_reg != 2'h0) begin
					sw_gap_next = sw_gap_reg - 2'h1;
				end else if (sw_phase) begin
					sw_gap_next = slot2 ? cdf_pkg::SW_GAP_LONG :
						cdf_pkg::SW_GAP_SHORT;
					sw_next = sw_cte && !sw_blocked;
				end
				smp_wait_next = smp_wait_reg - 8'(smp_wait_reg != 8'h00);
			end
			// Sample timer runs in cycles so oversampling is possible
			if (smp_wait_reg == 8'h00) begin
				if (smp_cyc_reg != 6'h00) begin
					smp_cyc_next = smp_cyc_reg - 6'h01;
				end else begin
					smp_cyc_next = spacing_cycles(in_ref ?
						first_sample_spacing : slot_spacing) - 6'h01;
					smp_next = smp_phase && smp_cte;
				end
			end
		end
		started_next = started_next && state_next != cdf_pkg::ST_IDLE;
		tone_next = state_next == cdf_pkg::ST_CTE && gen_cte && df_ok;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= cdf_pkg::ST_IDLE;
			idx_reg <= 4'h0;
			pos_reg <= 4'h0;
			match_reg <= 1'b0;
			expect_reg <= 1'b0;
			found_reg <= 1'b0;
			info_reg <= 8'h00;
			cte_us_reg <= 9'h000;
			len_reg <= 6'h00;
			started_reg <= 1'b0;
			sw_wait_reg <= 8'h00;
			sw_gap_reg <= 2'h0;
			smp_wait_reg <= 8'h00;
			smp_cyc_reg <= 6'h00;
			tone_reg <= 1'b0;
			sw_reg <= 1'b0;
			smp_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			pos_reg <= pos_next;
			match_reg <= match_next;
			expect_reg <= expect_next;
			found_reg <= found_next;
			info_reg <= info_next;
			cte_us_reg <= cte_us_next;
			len_reg <= len_next;
			started_reg <= started_next;
			sw_wait_reg <= sw_wait_next;
			sw_gap_reg <= sw_gap_next;
			smp_wait_reg <= smp_wait_next;
			smp_cyc_reg <= smp_cyc_next;
			tone_reg <= tone_next;
			sw_reg <= sw_next;
			smp_reg <= smp_next;
		end
	end

	assign cte_tone_tx = tone_reg;
	assign antenna_switch = sw_reg;
	assign iq_sample = smp_reg;
	assign procedure_active = state_reg == cdf_pkg::ST_CTE;
	assign cte_info_found = found_reg;
	assign cte_length_units = len_reg;
	assign slot_type = info_reg[7:6];

	// ==========================================================
	// Checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	AST_PHY_GATE: assert property (!df_ok |=> !cte_tone_tx)
		else $error("tone outside 1M or 2M mode");
	AST_TONE_TX: assert property (cte_tone_tx |-> $past(tx_mode))
		else $error("tone generated in receive");
	AST_SW_WINDOW: assert property (antenna_switch |-> $past(sw_phase))
		else $error("antenna switch outside guard or switch slot");
	AST_SMP_WINDOW: assert property (iq_sample |-> $past(smp_phase))
		else $error("sample outside reference or sample slot");
	AST_SW_GAP: assert property (antenna_switch |=> !antenna_switch [*8])
		else $error("antenna switches too close");
	AST_SMP_RX: assert property (iq_sample |-> !$past(tx_mode))
		else $error("sampling during transmit");
	AST_MIN_LEN: assert property (procedure_active |->
		cte_length_units >= cdf_pkg::CTE_MIN_UNITS || !use_inline)
		else $error("inline length below minimum");
	AST_MANUAL_LEN: assert property (state_reg == cdf_pkg::ST_HEADER &&
		crc_end_event && !use_inline |=>
		cte_length_units == $past(manual_length_setting))
		else $error("manual length not taken");
	AST_RSV_NOSW: assert property (sw_blocked |=> !antenna_switch)
		else $error("switching on reserved slot type");

	COV_TX: cover property (cte_tone_tx ##1 !cte_tone_tx);
	COV_SW: cover property (antenna_switch);
	COV_INLINE: cover property (use_inline && $rose(cte_info_found));
	COV_SMP: cover property (iq_sample && in_ref);

endmodule // cdf_direction_finding_ctrl

//--- src/cdf_pkg.sv
// Constants, encodings and state type for the tone extension controller.
// Assumes one 40 MHz core clock and a synchronous active-high reset.
//
// Summary of operation
// - Direction finding only in 1M or 2M modes
// - Transmit tone of ones, 16 to 160 us (code takes manual length setting unclamped)
// - Switch antennas only in guard or switch slots
// - Sample every us in reference, every sample slot
// - Switch and sample slots equal, 1 or 2 us
// - Mode and direction pick tone, sampling, switching
// - Inline receive takes settings from received header
// - Info octet present only when CP set
// - Position select picks data or advertising layout
// - Masked first byte match means second field present
// - Advertising: info flag checked if extended length nonzero
// - Earlier flag bits set shift info six octets
// - Match mask and value filter advertising types
// - Duration field in 8 us units, range limited
// - Duration 0 or 1 means 16 us
// - Slot type decode: AoA, 1 us, 2 us, reserved
// - Reference uses first spacing, then slot-type spacing
// - Manual mode: no parsing, manual length setting
// - Procedure trigger: CRC end or address event
// - Separate switch and sample offsets from trigger

package cdf_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int US_NS = 1000;
	localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
	localparam int GUARD_US = 4;
	localparam int REF_US = 8;
	localparam int CTE_MIN_US = 16;
	localparam int CTE_MAX_US = 160;
	localparam int CTE_UNIT_US = 8;
	localparam logic [5:0] CTE_MIN_UNITS = 6'(CTE_MIN_US / CTE_UNIT_US);
	localparam logic [5:0] CTE_MAX_UNITS = 6'(CTE_MAX_US / CTE_UNIT_US);
	localparam logic [5:0] CTE_RANGE_5BIT = 6'h1F;
	localparam logic [5:0] CTE_RANGE_6BIT = 6'h3F;
	localparam logic [1:0] SW_GAP_SHORT = 2'h1;
	localparam logic [1:0] SW_GAP_LONG = 2'h3;

	// ==========================================================
	// Header layout
	localparam int DATA_CP_BIT = 5;
	localparam logic [3:0] DATA_INFO_IDX = 4'h2;
	localparam logic [3:0] ADV_EXTLEN_IDX = 4'h2;
	localparam logic [3:0] ADV_FLAGS_IDX = 4'h3;
	localparam logic [3:0] ADV_INFO_IDX = 4'h4;
	localparam logic [3:0] ADV_INFO_SHIFT = 4'h6;
	localparam int ADV_INFO_FLAG_BIT = 2;

	// ==========================================================
	// Encodings
	localparam logic [1:0] PHY_1M = 2'h0;
	localparam logic [1:0] PHY_2M = 2'h1;
	localparam logic [1:0] SLOT_AOA = 2'h0;
	localparam logic [1:0] SLOT_AOD_1US = 2'h1;
	localparam logic [1:0] SLOT_AOD_2US = 2'h2;
	localparam logic [1:0] SLOT_RESERVED = 2'h3;
	localparam logic [1:0] RANGE_STD = 2'h0;
	localparam logic [1:0] RANGE_5BIT = 2'h1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_HEADER = 2'h1,
		ST_CTE = 2'h3
	} cdf_state_e;

endpackage

//--- src/cdf_us_tick.sv
// Microsecond tick generator for the tone extension controller.
// Assumes the 40 MHz core clock; restart realigns the tick phase.
`timescale 1ns/100ps

module cdf_us_tick (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Control
	input wire logic restart,
	output logic us_tick
);
	logic [5:0] cnt_reg, cnt_next;

	// ==========================================================
	// Counter
	always_comb begin
		if (restart || cnt_reg == 6'(cdf_pkg::US_CYCLES - 1)) begin
			cnt_next = 6'h00;
		end else begin
			cnt_next = cnt_reg + 6'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_reg <= 6'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign us_tick = !restart && cnt_reg == 6'(cdf_pkg::US_CYCLES - 1);

	// ==========================================================
	// Checks
	AST_TICK_RESTART: assert property (@(posedge core_clk) disable iff (reset)
		restart |=> !us_tick [*8])
		else $error("tick seen too soon after restart");

endmodule // cdf_us_tick

//--- verif/cdf_peer_model.sv
// Peer radio model: address event, header bytes, then CRC end.
// Assumes the bench calls send_packet just after a falling edge.
`timescale 1ns/100ps

module cdf_peer_model (
	// Clock
	input wire logic core_clk,
	// Radio events and header stream
	output logic address_event,
	output logic crc_end_event,
	output logic header_byte_valid,
	output logic [7:0] header_byte
);
	initial begin
		address_event = 1'b0;
		crc_end_event = 1'b0;
		header_byte_valid = 1'b0;
		header_byte = 8'h00;
	end

	// ==========================================================
	// Packet
	// Byte 0 sits in the low bits; gap idles before CRC end
	task automatic send_packet(input logic [95:0] hb, input int n,
		input int gap);
		address_event = 1'b1;
		@(negedge core_clk);
		address_event = 1'b0;
		for (int i = 0; i < n; i++) begin
			header_byte_valid = 1'b1;
			header_byte = hb[8*i +: 8];
			@(negedge core_clk);
		end
		header_byte_valid = 1'b0;
		// A stale byte is not held: show its inverse
		header_byte = ~header_byte;
		repeat (gap) @(negedge core_clk);
		crc_end_event = 1'b1;
		@(negedge core_clk);
		crc_end_event = 1'b0;
	endtask
endmodule // cdf_peer_model

//--- verif/testbench.sv
// Self-checking bench for the tone extension controller.
// Assumes the peer model drives the radio events and header bytes.
`timescale 1ns/100ps

module testbench;
	logic core_clk, reset, direction_mode_select, tx_mode;
	logic inline_cfg_enable, info_position_select, switch_spacing_long;
	logic procedure_trigger_select, address_event, crc_end_event;
	logic [1:0] phy_mode, duration_valid_range, rx_spacing_short_slots;
	logic [1:0] rx_spacing_long_slots, first_sample_spacing;
	logic [1:0] second_sample_spacing, slot_type, st;
	logic [7:0] header_match_mask, header_match_value, switch_offset;
	logic [7:0] sample_offset, header_byte;
	logic [5:0] manual_length_setting, cte_length_units, len;
	logic header_byte_valid, cte_tone_tx, antenna_switch, iq_sample;
	logic procedure_active, cte_info_found, found;
	logic [5:0] dur_in [5] = '{6'h00, 6'h01, 6'h1F, 6'h1F, 6'h21};
	logic [1:0] rng_in [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
	logic [5:0] dur_exp [5] = '{6'h02, 6'h02, 6'h14, 6'h1F, 6'h21};
	int failures, num_checks, act, tone, sw, smp, first_sw, sw_short;

	cdf_direction_finding_ctrl DUT (.core_clk, .reset, .phy_mode,
		.direction_mode_select, .tx_mode, .inline_cfg_enable,
		.info_position_select, .header_match_mask, .header_match_value,
		.duration_valid_range, .rx_spacing_short_slots,
		.rx_spacing_long_slots, .first_sample_spacing,
		.second_sample_spacing, .manual_length_setting,
		.switch_spacing_long, .procedure_trigger_select, .switch_offset,
		.sample_offset, .address_event, .crc_end_event, .header_byte_valid,
		.header_byte, .cte_tone_tx, .antenna_switch, .iq_sample,
		.procedure_active, .cte_info_found, .cte_length_units, .slot_type);

	cdf_peer_model peer (.core_clk, .address_event, .crc_end_event,
		.header_byte_valid, .header_byte);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ==========================================================
	// Reporting
	task automatic close_out();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check_val(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// ==========================================================
	// Access
	task automatic cfg(input logic [1:0] phy, input logic dir,
		input logic tx, input logic inl, input logic pos);
		phy_mode = phy;
		direction_mode_select = dir;
		tx_mode = tx;
		inline_cfg_enable = inl;
		info_position_select = pos;
	endtask

	// Sends one packet and measures the extension that follows it
	task automatic run(input logic [95:0] hb, input int n);
		act = 0;
		tone = 0;
		sw = 0;
		smp = 0;
		first_sw = -1;
		found = 1'b0;
		peer.send_packet(hb, n, 3);
		for (int i = 0; i < 21000; i++) begin
			if (procedure_active !== 1'b1 && (act > 0 || i > 40)) begin
				break;
			end
			if (procedure_active === 1'b1) begin
				if (act == 0) begin
					found = cte_info_found;
					len = cte_length_units;
					st = slot_type;
				end
				act++;
			end
			if (antenna_switch === 1'b1 && first_sw < 0) begin
				first_sw = i;
			end
			tone += int'(cte_tone_tx === 1'b1);
			sw += int'(antenna_switch === 1'b1);
			smp += int'(iq_sample === 1'b1);
			@(negedge core_clk);
		end
		if (procedure_active === 1'b1) begin
			failures++;
			$display("CHECK FAILED procedure end expected 0 seen 1");
			close_out();
		end
	endtask

	// ==========================================================
	// Tests
	initial begin
		failures = 0;
		num_checks = 0;
		reset = 1'b1;
		cfg(2'h0, 1'b0, 1'b1, 1'b0, 1'b0);
		header_match_mask = 8'h00;
		header_match_value = 8'h00;
		duration_valid_range = 2'h0;
		rx_spacing_short_slots = 2'h0;
		rx_spacing_long_slots = 2'h1;
		first_sample_spacing = 2'h0;
		second_sample_spacing = 2'h0;
		manual_length_setting = 6'h02;
		switch_spacing_long = 1'b0;
		procedure_trigger_select = 1'b0;
		switch_offset = 8'h0E;
		sample_offset = 8'h03;
		repeat (6) @(negedge core_clk);
		reset = 1'b0;
		check_val("outputs at reset", 16'h0, 16'({cte_tone_tx,
			antenna_switch, iq_sample, procedure_active, cte_info_found,
			cte_length_units, slot_type}));
		for (int p = 0; p < 2; p++) begin
			cfg(2'(p), 1'b0, 1'b1, 1'b0, 1'b0);
			run(96'h0, 0);
			check_val("aoa tx active", 16'h280, 16'(act));
			check_val("aoa tx tone", 16'h280, 16'(tone));
			check_val("aoa tx switches", 16'h0, 16'(sw));
			check_val("aoa tx samples", 16'h0, 16'(smp));
		end
		cfg(2'h2, 1'b1, 1'b1, 1'b0, 1'b0);
		run(96'h0, 0);
		check_val("bad phy active", 16'h0, 16'(act + tone));
		cfg(2'h1, 1'b1, 1'b1, 1'b0, 1'b0);
		procedure_trigger_select = 1'b1;
		manual_length_setting = 6'h03;
		run(96'h0, 0);
		check_val("aod tx tone", 16'h3C0, 16'(tone));
		check_val("aod tx switches", 16'h1, 16'(sw > 0));
		check_val("aod tx samples", 16'h0, 16'(smp));
		// Slot lengths follow one setting, so they stay equal
		cfg(2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
		procedure_trigger_select = 1'b0;
		manual_length_setting = 6'h02;
		run(96'h0, 0);
		sw_short = sw;
		check_val("aoa rx tone", 16'h0, 16'(tone));
		check_val("aoa rx samples", 16'h1, 16'(smp >= 8));
		check_val("first switch", 16'h1,
			16'(first_sw >= 560 && first_sw <= 640));
		switch_spacing_long = 1'b1;
		run(96'h0, 0);
		check_val("long slot switches", 16'h1, 16'(sw < sw_short));
		cfg(2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
		run(96'h0, 0);
		check_val("aod rx switches", 16'h0, 16'(sw));
		check_val("aod rx samples", 16'h1, 16'(smp > 0));
		// Data layout: 1-byte first field, 8-bit length
		cfg(2'h0, 1'b1, 1'b0, 1'b1, 1'b1);
		for (int t = 0; t < 4; t++) begin
			run(96'({2'(t), 6'h02, 8'h10, 8'h20}), 3);
			check_val("data info", 16'h1, 16'(found));
			check_val("slot type", 16'(t), 16'(st));
			check_val("data length", 16'h2, 16'(len));
		end
		for (int k = 0; k < 5; k++) begin
			duration_valid_range = rng_in[k];
			run(96'({2'h1, dur_in[k], 8'h10, 8'h20}), 3);
			check_val("duration", 16'(dur_exp[k]), 16'(len));
			check_val("duration time", 16'(dur_exp[k]) * 16'h140,
				16'(act));
		end
		duration_valid_range = 2'h0;
		run(96'({8'h42, 8'h10, 8'h00}), 3);
		check_val("cp clear", 16'h0, 16'(act));
		header_match_mask = 8'h0F;
		header_match_value = 8'h01;
		run(96'({8'h42, 8'h10, 8'h20}), 3);
		check_val("mask miss", 16'h0, 16'(act));
		run(96'({8'h42, 8'h10, 8'h21}), 3);
		check_val("mask hit", 16'h1, 16'(found));
		cfg(2'h0, 1'b0, 1'b0, 1'b1, 1'b1);
		run(96'({8'hC2, 8'h10, 8'h21}), 3);
		check_val("reserved switches", 16'h0, 16'(sw));
		cfg(2'h0, 1'b1, 1'b0, 1'b1, 1'b0);
		header_match_mask = 8'h00;
		header_match_value = 8'h00;
		run(96'({8'h42, 8'h04, 8'h05, 8'h10, 8'h07}), 5);
		check_val("adv info", 16'h1, 16'(found));
		check_val("adv type", 16'h1, 16'(st));
		run(96'({8'h83, 40'h0, 8'h42, 8'h05, 8'h05, 8'h10, 8'h07}), 11);
		check_val("shifted length", 16'h3, 16'(len));
		check_val("shifted type", 16'h2, 16'(st));
		run(96'({8'h42, 8'h04, 8'h00, 8'h10, 8'h07}), 5);
		check_val("no ext header", 16'h0, 16'(act));
		header_match_mask = 8'h0F;
		header_match_value = 8'h07;
		run(96'({8'h42, 8'h04, 8'h05, 8'h10, 8'h00}), 5);
		check_val("pdu filtered", 16'h0, 16'(act));
		run(96'({8'h42, 8'h04, 8'h05, 8'h10, 8'h47}), 5);
		check_val("pdu accepted", 16'h1, 16'(found));
		close_out();
	end
endmodule // testbench
